/* hdl/rcfi_pkg.sv */
// Constants, encodings and state codes for the remap cache fill and invalidate block
// How it works
// - Hardware runs with fault caching flag clear
// - No context fill on root fetch/present/field faults
// - No context fill on context or reserved faults
// - Flag set: fills with no present context entry tagged domain zero
// - Buffer entry holds translation plus cumulative permissions
// - Buffer keeps only walks granting read or write
// - No buffer fill on fetch, permission, field faults
// - Non-leaf cache skips faulting directory entries
// - Partial permissions both clear: no non-leaf fill
// - Non-leaf caching invisible except invalidation hint
// - Flag clear: no interrupt entry fill on fault
// - Register invalidation interface always present
// - Invalidation is write then poll, low latency
// - Commands execute regardless of remap enable state
// - Context invalidation: global, domain, device granularity
// - Unsupported granularity falls back to coarser one
package rcfi_pkg;
  localparam int RCFI_DID_W     = 16;
  localparam int RCFI_SID_W     = 16;
  localparam int RCFI_PAGE_W    = 20;
  localparam int RCFI_CTX_DEPTH = 8;
  localparam int RCFI_TLB_DEPTH = 8;
  // Hardware must report the fault caching flag clear
  localparam logic RCFI_CM_HW   = 1'b0;
  // Tag for faulting entries cached without a present context entry
  localparam logic [RCFI_DID_W-1:0] RCFI_RSVD_DID = 16'h0000;
  // Granularity codes, requested and performed
  localparam logic [1:0] RCFI_GRAN_NONE   = 2'h0;
  localparam logic [1:0] RCFI_GRAN_GLOBAL = 2'h1;
  localparam logic [1:0] RCFI_GRAN_DOMAIN = 2'h2;
  localparam logic [1:0] RCFI_GRAN_DEVICE = 2'h3;
  // Function mask codes: low source-id bits kept in the compare
  localparam logic [2:0] RCFI_FM_KEEP0 = 3'h7;
  localparam logic [2:0] RCFI_FM_KEEP1 = 3'h3;
  localparam logic [2:0] RCFI_FM_KEEP2 = 3'h1;
  localparam logic [2:0] RCFI_FM_KEEP3 = 3'h0;
  localparam int         RCFI_FM_BITS  = 3;
  typedef enum logic [1:0] {
    RCFI_ST_IDLE  = 2'b01,
    RCFI_ST_INVAL = 2'b10
  } rcfi_state_e;
endpackage

/* hdl/rcfi_fill_filter.sv */
// Fill admission decisions for the context, translation, non-leaf and interrupt caches
`timescale 1ns/1ps
module rcfi_fill_filter
  import rcfi_pkg::*;
#(
  parameter int DID_W         = RCFI_DID_W,
  parameter bit NONLEAF_EN    = 1'b1,
  parameter bit PARTIAL_PERMS = 1'b1
) (
  // Mode
  input  wire logic             cm_i,
  // Context walk outcome
  input  wire logic             root_fetch_err_i,
  input  wire logic             root_not_present_i,
  input  wire logic             root_invalid_i,
  input  wire logic             ctx_fetch_err_i,
  input  wire logic             ctx_not_present_i,
  input  wire logic             ctx_invalid_i,
  input  wire logic             rsvd_nonzero_i,
  input  wire logic [DID_W-1:0] ctx_did_i,
  // Page walk outcome
  input  wire logic             dir_fetch_err_i,
  input  wire logic             entry_rw_clear_i,
  input  wire logic             entry_invalid_i,
  input  wire logic             entry_rsvd_i,
  input  wire logic             cum_r_i,
  input  wire logic             cum_w_i,
  input  wire logic             part_r_i,
  input  wire logic             part_w_i,
  // Interrupt lookup outcome
  input  wire logic             ir_fault_i,
  // Decisions
  output logic                  ctx_ok_o,
  output logic [DID_W-1:0]      ctx_tag_o,
  output logic                  tlb_ok_o,
  output logic                  nl_ok_o,
  output logic                  iec_ok_o
);
  logic root_fault;
  logic ctx_fault;
  logic walk_fault;
  logic part_clear;

  assign root_fault = root_fetch_err_i | root_not_present_i | root_invalid_i;
  assign ctx_fault  = root_fault | ctx_fetch_err_i | ctx_not_present_i
                    | ctx_invalid_i | rsvd_nonzero_i;
  assign walk_fault = ctx_fault | dir_fetch_err_i | entry_rw_clear_i
                    | entry_invalid_i | entry_rsvd_i;
  assign part_clear = PARTIAL_PERMS & ~part_r_i & ~part_w_i;

  assign ctx_ok_o  = cm_i | ~ctx_fault;
  // No present context entry means no real domain to tag with
  assign ctx_tag_o = (root_fault | ctx_fetch_err_i | ctx_not_present_i) ?
                     RCFI_RSVD_DID : ctx_did_i;
  assign tlb_ok_o  = cm_i | (~walk_fault & (cum_r_i | cum_w_i));
  assign nl_ok_o   = NONLEAF_EN & (cm_i | (~walk_fault & ~part_clear));
  assign iec_ok_o  = cm_i | ~ir_fault_i;
endmodule

/* hdl/rcfi_top.sv */
// Context cache, translation buffer and register invalidation for the remap unit
`timescale 1ns/1ps
module rcfi_top
  import rcfi_pkg::*;
#(
  parameter int DID_W         = RCFI_DID_W,
  parameter int SID_W         = RCFI_SID_W,
  parameter int PAGE_W        = RCFI_PAGE_W,
  parameter int CTX_DEPTH     = RCFI_CTX_DEPTH,
  parameter int TLB_DEPTH     = RCFI_TLB_DEPTH,
  parameter bit DOMAIN_SEL    = 1'b1,
  parameter bit DEVICE_SEL    = 1'b1,
  parameter bit NONLEAF_EN    = 1'b1,
  parameter bit PARTIAL_PERMS = 1'b1
) (
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // Remap enable status (does not gate invalidation)
  input  wire logic              translation_enabled_status_i,
  input  wire logic              interrupt_remap_enabled_status_i,
  // Context invalidation command
  input  wire logic              ctx_inv_req_i,
  input  wire logic [1:0]        ctx_inv_gran_i,
  input  wire logic [DID_W-1:0]  ctx_inv_did_i,
  input  wire logic [SID_W-1:0]  ctx_inv_sid_i,
  input  wire logic [1:0]        ctx_inv_fm_i,
  // Translation buffer flush
  input  wire logic              tlb_flush_i,
  // Context fill
  input  wire logic              ctx_fill_i,
  input  wire logic [SID_W-1:0]  ctx_fill_sid_i,
  input  wire logic [DID_W-1:0]  ctx_fill_did_i,
  input  wire logic              root_fetch_err_i,
  input  wire logic              root_not_present_i,
  input  wire logic              root_invalid_i,
  input  wire logic              ctx_fetch_err_i,
  input  wire logic              ctx_not_present_i,
  input  wire logic              ctx_invalid_i,
  input  wire logic              rsvd_nonzero_i,
  // Page walk fill
  input  wire logic              tlb_fill_i,
  input  wire logic              nl_fill_i,
  input  wire logic [DID_W-1:0]  walk_did_i,
  input  wire logic [PAGE_W-1:0] walk_page_i,
  input  wire logic [PAGE_W-1:0] walk_xlate_i,
  input  wire logic              dir_fetch_err_i,
  input  wire logic              entry_rw_clear_i,
  input  wire logic              entry_invalid_i,
  input  wire logic              entry_rsvd_i,
  input  wire logic              cum_r_i,
  input  wire logic              cum_w_i,
  input  wire logic              part_r_i,
  input  wire logic              part_w_i,
  // Interrupt entry fill
  input  wire logic              iec_fill_i,
  input  wire logic              ir_fault_i,
  // Lookups
  input  wire logic              ctx_lookup_i,
  input  wire logic [SID_W-1:0]  ctx_lookup_sid_i,
  input  wire logic              tlb_lookup_i,
  input  wire logic [DID_W-1:0]  tlb_lookup_did_i,
  input  wire logic [PAGE_W-1:0] tlb_lookup_page_i,
  // Status
  output logic                   cache_faults_report_o,
  output logic                   ctx_inv_busy_o,
  output logic [1:0]             ctx_inv_done_gran_o,
  // Fill acceptance pulses
  output logic                   ctx_fill_taken_o,
  output logic                   tlb_fill_taken_o,
  output logic                   nl_fill_taken_o,
  output logic                   iec_fill_taken_o,
  // Lookup results
  output logic                   ctx_hit_o,
  output logic [DID_W-1:0]       ctx_hit_did_o,
  output logic                   tlb_hit_o,
  output logic [PAGE_W-1:0]      tlb_xlate_o,
  output logic                   tlb_r_o,
  output logic                   tlb_w_o
);
  localparam int CI_W = $clog2(CTX_DEPTH);
  localparam int TI_W = $clog2(TLB_DEPTH);

  typedef struct packed {
    rcfi_state_e                   fsm;
    logic                          pend;
    logic [1:0]                    gran;
    logic [DID_W-1:0]              did;
    logic [SID_W-1:0]              sid;
    logic [1:0]                    fm;
    logic [1:0]                    done_gran;
    logic [CTX_DEPTH-1:0]          cv;
    logic [CTX_DEPTH-1:0][DID_W-1:0] cdid;
    logic [CTX_DEPTH-1:0][SID_W-1:0] csid;
    logic [CI_W-1:0]               cptr;
    logic [TLB_DEPTH-1:0]          tv;
    logic [TLB_DEPTH-1:0][DID_W-1:0] tdid;
    logic [TLB_DEPTH-1:0][PAGE_W-1:0] tpage;
    logic [TLB_DEPTH-1:0][PAGE_W-1:0] txl;
    logic [TLB_DEPTH-1:0]          tr;
    logic [TLB_DEPTH-1:0]          tw;
    logic [TI_W-1:0]               tptr;
    logic                          ctx_taken;
    logic                          tlb_taken;
    logic                          nl_taken;
    logic                          iec_taken;
    logic                          ctx_hit;
    logic [DID_W-1:0]              ctx_hit_did;
    logic                          tlb_hit;
    logic [PAGE_W-1:0]             tlb_xl;
    logic                          tlb_r;
    logic                          tlb_w;
  } rcfi_core_s;

  rcfi_core_s st_reg;
  rcfi_core_s st_next;

  logic             ctx_ok;
  logic [DID_W-1:0] ctx_tag;
  logic             tlb_ok;
  logic             nl_ok;
  logic             iec_ok;
  logic [1:0]       eff_gran;
  logic [SID_W-1:0] sid_keep;

  ////////////////////////////////////////////////////////////////////////////
  rcfi_fill_filter #(
    .DID_W         (DID_W),
    .NONLEAF_EN    (NONLEAF_EN),
    .PARTIAL_PERMS (PARTIAL_PERMS)
  ) u_filter (
    .cm_i               (RCFI_CM_HW),
    .root_fetch_err_i   (root_fetch_err_i),
    .root_not_present_i (root_not_present_i),
    .root_invalid_i     (root_invalid_i),
    .ctx_fetch_err_i    (ctx_fetch_err_i),
    .ctx_not_present_i  (ctx_not_present_i),
    .ctx_invalid_i      (ctx_invalid_i),
    .rsvd_nonzero_i     (rsvd_nonzero_i),
    .ctx_did_i          (ctx_fill_did_i),
    .dir_fetch_err_i    (dir_fetch_err_i),
    .entry_rw_clear_i   (entry_rw_clear_i),
    .entry_invalid_i    (entry_invalid_i),
    .entry_rsvd_i       (entry_rsvd_i),
    .cum_r_i            (cum_r_i),
    .cum_w_i            (cum_w_i),
    .part_r_i           (part_r_i),
    .part_w_i           (part_w_i),
    .ir_fault_i         (ir_fault_i),
    .ctx_ok_o           (ctx_ok),
    .ctx_tag_o          (ctx_tag),
    .tlb_ok_o           (tlb_ok),
    .nl_ok_o            (nl_ok),
    .iec_ok_o           (iec_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Coarser fallback when a granularity is not built in
  always_comb begin
    case (st_reg.gran)
      RCFI_GRAN_DEVICE: eff_gran = DEVICE_SEL ? RCFI_GRAN_DEVICE :
                                   (DOMAIN_SEL ? RCFI_GRAN_DOMAIN : RCFI_GRAN_GLOBAL);
      RCFI_GRAN_DOMAIN: eff_gran = DOMAIN_SEL ? RCFI_GRAN_DOMAIN : RCFI_GRAN_GLOBAL;
      default:          eff_gran = RCFI_GRAN_GLOBAL;
    endcase
  end

  always_comb begin
    sid_keep = '1;
    case (st_reg.fm)
      2'h0:    sid_keep[RCFI_FM_BITS-1:0] = RCFI_FM_KEEP0;
      2'h1:    sid_keep[RCFI_FM_BITS-1:0] = RCFI_FM_KEEP1;
      2'h2:    sid_keep[RCFI_FM_BITS-1:0] = RCFI_FM_KEEP2;
      default: sid_keep[RCFI_FM_BITS-1:0] = RCFI_FM_KEEP3;
    endcase
  end

  // Per-entry match vectors
  logic [CTX_DEPTH-1:0] c_kill;
  logic [CTX_DEPTH-1:0] c_look;
  logic [TLB_DEPTH-1:0] t_look;

  genvar g;
  generate
    for (g = 0; g < CTX_DEPTH; g++) begin : g_ctx
      assign c_kill[g] = (eff_gran == RCFI_GRAN_GLOBAL)
                       | ((eff_gran == RCFI_GRAN_DOMAIN) & (st_reg.cdid[g] == st_reg.did))
                       | ((eff_gran == RCFI_GRAN_DEVICE) & (st_reg.cdid[g] == st_reg.did)
                          & ((st_reg.csid[g] & sid_keep) == (st_reg.sid & sid_keep)));
      assign c_look[g] = st_reg.cv[g] & (st_reg.csid[g] == ctx_lookup_sid_i);
    end
    for (g = 0; g < TLB_DEPTH; g++) begin : g_tlb
      assign t_look[g] = st_reg.tv[g] & (st_reg.tdid[g] == tlb_lookup_did_i)
                       & (st_reg.tpage[g] == tlb_lookup_page_i);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.ctx_taken = 1'b0;
    st_next.tlb_taken = 1'b0;
    st_next.nl_taken  = 1'b0;
    st_next.iec_taken = 1'b0;
    // Fills
    if (ctx_fill_i && ctx_ok) begin
      st_next.cv[st_reg.cptr]   = 1'b1;
      st_next.cdid[st_reg.cptr] = ctx_tag;
      st_next.csid[st_reg.cptr] = ctx_fill_sid_i;
      st_next.cptr              = (st_reg.cptr == CI_W'(CTX_DEPTH - 1)) ? '0 :
                                  st_reg.cptr + CI_W'(1);
      st_next.ctx_taken         = 1'b1;
    end
    if (tlb_fill_i && tlb_ok) begin
      st_next.tv[st_reg.tptr]    = 1'b1;
      st_next.tdid[st_reg.tptr]  = walk_did_i;
      st_next.tpage[st_reg.tptr] = walk_page_i;
      st_next.txl[st_reg.tptr]   = walk_xlate_i;
      st_next.tr[st_reg.tptr]    = cum_r_i;
      st_next.tw[st_reg.tptr]    = cum_w_i;
      st_next.tptr               = (st_reg.tptr == TI_W'(TLB_DEPTH - 1)) ? '0 :
                                   st_reg.tptr + TI_W'(1);
      st_next.tlb_taken          = 1'b1;
    end
    st_next.nl_taken  = nl_fill_i & nl_ok;
    st_next.iec_taken = iec_fill_i & iec_ok;
    // Flush wins over a same-cycle fill so no stale entry survives
    if (tlb_flush_i) begin
      st_next.tv = '0;
    end
    // Lookups, only meaningful while translation is on
    st_next.ctx_hit     = ctx_lookup_i & translation_enabled_status_i & (|c_look);
    st_next.ctx_hit_did = '0;
    for (int i = 0; i < CTX_DEPTH; i++) begin
      if (c_look[i]) begin
        st_next.ctx_hit_did = st_reg.cdid[i];
      end
    end
    st_next.tlb_hit = tlb_lookup_i & translation_enabled_status_i & (|t_look);
    st_next.tlb_xl  = '0;
    st_next.tlb_r   = 1'b0;
    st_next.tlb_w   = 1'b0;
    for (int i = 0; i < TLB_DEPTH; i++) begin
      if (t_look[i]) begin
        st_next.tlb_xl = st_reg.txl[i];
        st_next.tlb_r  = st_reg.tr[i];
        st_next.tlb_w  = st_reg.tw[i];
      end
    end
    // Invalidation engine; remap enables deliberately not consulted
    case (st_reg.fsm)
      RCFI_ST_IDLE: begin
        if (ctx_inv_req_i) begin
          st_next.pend = 1'b1;
          st_next.gran = ctx_inv_gran_i;
          st_next.did  = ctx_inv_did_i;
          st_next.sid  = ctx_inv_sid_i;
          st_next.fm   = ctx_inv_fm_i;
          st_next.fsm  = RCFI_ST_INVAL;
        end
      end
      RCFI_ST_INVAL: begin
        // Applied after fills; a racing fill is removed on global, else only if its slot's old tags matched
        st_next.cv        = st_next.cv & ~c_kill;
        st_next.pend      = 1'b0;
        st_next.done_gran = eff_gran;
        st_next.fsm       = RCFI_ST_IDLE;
      end
      default: begin
        st_next.fsm  = RCFI_ST_IDLE;
        st_next.pend = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg           <= '0;
      st_reg.fsm       <= RCFI_ST_IDLE;
      st_reg.done_gran <= RCFI_GRAN_NONE;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign cache_faults_report_o = RCFI_CM_HW;
  assign ctx_inv_busy_o        = st_reg.pend;
  assign ctx_inv_done_gran_o   = st_reg.done_gran;
  assign ctx_fill_taken_o      = st_reg.ctx_taken;
  assign tlb_fill_taken_o      = st_reg.tlb_taken;
  assign nl_fill_taken_o       = st_reg.nl_taken;
  assign iec_fill_taken_o      = st_reg.iec_taken;
  assign ctx_hit_o             = st_reg.ctx_hit;
  assign ctx_hit_did_o         = st_reg.ctx_hit_did;
  assign tlb_hit_o             = st_reg.tlb_hit;
  assign tlb_xlate_o           = st_reg.tlb_xl;
  assign tlb_r_o               = st_reg.tlb_r;
  assign tlb_w_o               = st_reg.tlb_w;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic root_flt;
  logic ctx_flt;
  assign root_flt = root_fetch_err_i | root_not_present_i | root_invalid_i;
  assign ctx_flt  = ctx_fetch_err_i | ctx_not_present_i | ctx_invalid_i | rsvd_nonzero_i;

  sequence s_cmd_taken;
    ce_i && ctx_inv_req_i && !ctx_inv_busy_o;
  endsequence
  sequence s_busy_then_done;
    ctx_inv_busy_o ##1 (!ctx_inv_busy_o && ctx_inv_done_gran_o != RCFI_GRAN_NONE);
  endsequence

  AST_CM_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !cache_faults_report_o) else $error("fault caching flag reported set");
  AST_ROOT_NOFILL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && ctx_fill_i && root_flt |=> !ctx_fill_taken_o)
    else $error("context filled after root fault");
  AST_CTX_NOFILL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && ctx_fill_i && ctx_flt |=> !ctx_fill_taken_o)
    else $error("context filled after context fault");
  AST_CTX_FILL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && ctx_fill_i && !root_flt && !ctx_flt |=> ctx_fill_taken_o)
    else $error("clean context walk not cached");
  AST_RSVD_TAG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctx_fill_i && ctx_ok |-> ctx_tag == ((root_flt || ctx_fetch_err_i || ctx_not_present_i) ?
    RCFI_RSVD_DID : ctx_fill_did_i)) else $error("cached context entry has wrong domain tag");
  AST_TLB_PERM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && tlb_fill_i && !cum_r_i && !cum_w_i |=> !tlb_fill_taken_o)
    else $error("walk without permissions cached");
  AST_TLB_FAULT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && tlb_fill_i && (dir_fetch_err_i || entry_rsvd_i || entry_invalid_i)
    |=> !tlb_fill_taken_o) else $error("faulting walk cached");
  AST_NL_FAULT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && nl_fill_i && (ctx_flt || root_flt || entry_rw_clear_i) |=> !nl_fill_taken_o)
    else $error("faulting directory entry cached");
  AST_NL_PART: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && nl_fill_i && PARTIAL_PERMS && !part_r_i && !part_w_i |=> !nl_fill_taken_o)
    else $error("directory entry without partial permissions cached");
  AST_IEC_FAULT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && iec_fill_i && ir_fault_i |=> !iec_fill_taken_o)
    else $error("faulting interrupt entry cached");
  AST_INV_DONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_cmd_taken ##1 ce_i |-> s_busy_then_done)
    else $error("invalidation did not complete in two cycles");
  AST_INV_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_cmd_taken and (!translation_enabled_status_i && !interrupt_remap_enabled_status_i))
    |=> ctx_inv_busy_o) else $error("command ignored with remapping off");
  AST_GLOBAL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && st_reg.fsm == RCFI_ST_INVAL && eff_gran == RCFI_GRAN_GLOBAL |=> st_reg.cv == '0)
    else $error("global invalidation left entries");
  AST_COARSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && st_reg.fsm == RCFI_ST_INVAL && !DEVICE_SEL && st_reg.gran == RCFI_GRAN_DEVICE
    |=> ctx_inv_done_gran_o != RCFI_GRAN_DEVICE) else $error("unsupported granularity reported");
endmodule

/* tb/tb.sv */
// Self-checking bench for the remap cache fill and invalidate block
`timescale 1ns/1ps
module tb;
  import rcfi_pkg::*;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
  logic        translation_enabled_status_i, interrupt_remap_enabled_status_i;
  logic        ctx_inv_req_i, tlb_flush_i, ctx_fill_i, tlb_fill_i, nl_fill_i, iec_fill_i;
  logic        ir_fault_i, ctx_lookup_i, tlb_lookup_i;
  logic [1:0]  ctx_inv_gran_i, ctx_inv_fm_i, ctx_inv_done_gran_o;
  logic [15:0] ctx_inv_did_i, ctx_inv_sid_i, ctx_fill_sid_i, ctx_fill_did_i, walk_did_i;
  logic [15:0] ctx_lookup_sid_i, tlb_lookup_did_i, ctx_hit_did_o;
  logic [19:0] walk_page_i, walk_xlate_i, tlb_lookup_page_i, tlb_xlate_o;
  logic        root_fetch_err_i, root_not_present_i, root_invalid_i, ctx_fetch_err_i;
  logic        ctx_not_present_i, ctx_invalid_i, rsvd_nonzero_i;
  logic        dir_fetch_err_i, entry_rw_clear_i, entry_invalid_i, entry_rsvd_i;
  logic        cum_r_i, cum_w_i, part_r_i, part_w_i;
  logic        cache_faults_report_o, ctx_inv_busy_o, ctx_fill_taken_o, tlb_fill_taken_o;
  logic        nl_fill_taken_o, iec_fill_taken_o, ctx_hit_o, tlb_hit_o, tlb_r_o, tlb_w_o;
  int          num_errors = 0, total_checks = 0, seed = 14;
  // Context cache model; stays under depth so replacement never matters
  logic [15:0] m_sid[$], m_did[$];
  // Page of the newest cached walk, used to prove the flush
  logic [19:0] last_pg = 20'h0;

  always #25 clk_i = ~clk_i;

  rcfi_top i_rcfi_top (
    .clk_i, .rst_n_i, .ce_i, .translation_enabled_status_i, .interrupt_remap_enabled_status_i,
    .ctx_inv_req_i, .ctx_inv_gran_i, .ctx_inv_did_i, .ctx_inv_sid_i, .ctx_inv_fm_i,
    .tlb_flush_i, .ctx_fill_i, .ctx_fill_sid_i, .ctx_fill_did_i, .root_fetch_err_i,
    .root_not_present_i, .root_invalid_i, .ctx_fetch_err_i, .ctx_not_present_i,
    .ctx_invalid_i, .rsvd_nonzero_i, .tlb_fill_i, .nl_fill_i, .walk_did_i, .walk_page_i,
    .walk_xlate_i, .dir_fetch_err_i, .entry_rw_clear_i, .entry_invalid_i, .entry_rsvd_i,
    .cum_r_i, .cum_w_i, .part_r_i, .part_w_i, .iec_fill_i, .ir_fault_i, .ctx_lookup_i,
    .ctx_lookup_sid_i, .tlb_lookup_i, .tlb_lookup_did_i, .tlb_lookup_page_i,
    .cache_faults_report_o, .ctx_inv_busy_o, .ctx_inv_done_gran_o, .ctx_fill_taken_o,
    .tlb_fill_taken_o, .nl_fill_taken_o, .iec_fill_taken_o, .ctx_hit_o, .ctx_hit_did_o,
    .tlb_hit_o, .tlb_xlate_o, .tlb_r_o, .tlb_w_o
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [19:0] seen, logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Inputs change at the falling edge only
  task automatic step;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic cfill(logic [15:0] sid, logic [15:0] did, logic [6:0] f);
    ctx_fill_i = 1'b1;
    ctx_fill_sid_i = sid;
    ctx_fill_did_i = did;
    {root_fetch_err_i, root_not_present_i, root_invalid_i, ctx_fetch_err_i,
     ctx_not_present_i, ctx_invalid_i, rsvd_nonzero_i} = f;
    step;
    chk("ctx_taken", ctx_fill_taken_o, f == 7'h00);
    if (f == 7'h00) begin
      m_sid.push_back(sid);
      m_did.push_back(did);
    end
  endtask

  task automatic probe(logic [15:0] sid);
    logic        h;
    logic [15:0] d;
    h = 1'b0;
    d = 16'h0000;
    for (int k = 0; k < m_sid.size(); k++) if (m_sid[k] == sid) {h, d} = {1'b1, m_did[k]};
    ctx_lookup_i = 1'b1;
    ctx_lookup_sid_i = sid;
    step;
    chk("ctx_hit", ctx_hit_o, h);
    chk("ctx_hit_did", ctx_hit_did_o, d);
  endtask

  task automatic probes;
    probe(16'h0107); probe(16'h0010); probe(16'h0013); probe(16'h0020); probe(16'h0030);
    ctx_lookup_i = 1'b0;
  endtask

  // Enables are random here: commands must run whatever the remap state
  task automatic inval(logic [1:0] g, logic [15:0] did, logic [15:0] sid, logic [1:0] fm);
    logic [15:0] ign;
    ign = (fm == 2'h0) ? 16'h0 : (fm == 2'h1) ? 16'h4 : (fm == 2'h2) ? 16'h6 : 16'h7;
    {translation_enabled_status_i, interrupt_remap_enabled_status_i} = 2'($random(seed));
    {ctx_inv_req_i, ctx_inv_gran_i, ctx_inv_did_i, ctx_inv_sid_i, ctx_inv_fm_i} =
      {1'b1, g, did, sid, fm};
    step;
    ctx_inv_req_i = 1'b0;
    chk("inv_busy", ctx_inv_busy_o, 1'b1);
    step;
    chk("inv_busy", ctx_inv_busy_o, 1'b0);
    chk("done_gran", ctx_inv_done_gran_o, g);
    for (int k = m_sid.size() - 1; k >= 0; k--)
      if (g == RCFI_GRAN_GLOBAL || (m_did[k] == did && (g == RCFI_GRAN_DOMAIN ||
          ((m_sid[k] ^ sid) & ~ign) == 16'h0))) begin
        m_sid.delete(k);
        m_did.delete(k);
      end
    translation_enabled_status_i = 1'b1;
    probes;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {ctx_inv_req_i, tlb_flush_i, ctx_fill_i, tlb_fill_i, nl_fill_i, iec_fill_i} = '0;
    {ir_fault_i, ctx_lookup_i, tlb_lookup_i, ctx_inv_gran_i, ctx_inv_fm_i} = '0;
    {ctx_inv_did_i, ctx_inv_sid_i, ctx_fill_sid_i, ctx_fill_did_i, walk_did_i} = '0;
    {ctx_lookup_sid_i, tlb_lookup_did_i, walk_page_i, walk_xlate_i, tlb_lookup_page_i} = '0;
    {root_fetch_err_i, root_not_present_i, root_invalid_i, ctx_fetch_err_i} = '0;
    {ctx_not_present_i, ctx_invalid_i, rsvd_nonzero_i, dir_fetch_err_i} = '0;
    {entry_rw_clear_i, entry_invalid_i, entry_rsvd_i, cum_r_i, cum_w_i} = '0;
    {part_r_i, part_w_i, translation_enabled_status_i, interrupt_remap_enabled_status_i} = 4'h2;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    chk("fault_report", cache_faults_report_o, 1'b0);
    chk("done_gran", ctx_inv_done_gran_o, RCFI_GRAN_NONE);
    $display("test reset done");
    // Back-to-back fills: one clean, each fault alone, then more clean ones
    for (int f = 7; f >= 0; f--) cfill(16'h0100 + 16'(f), 16'h0001, 7'((1 << f) & 8'h7f));
    cfill(16'h0010, 16'h0005, 7'h00);
    cfill(16'h0013, 16'h0005, 7'h00);
    cfill(16'h0020, 16'h0005, 7'h00);
    cfill(16'h0030, 16'h0007, 7'h00);
    ctx_fill_i = 1'b0;
    probes;
    inval(RCFI_GRAN_DEVICE, 16'h0005, 16'h0017, 2'h3);
    inval(RCFI_GRAN_DEVICE, 16'h0005, 16'h0024, 2'h1);
    inval(RCFI_GRAN_DOMAIN, 16'h0007, 16'h0000, 2'h0);
    inval(RCFI_GRAN_GLOBAL, 16'h0000, 16'h0000, 2'h0);
    $display("test context done");
    // Every fault, permission and interrupt-fault mix; low page bits keep pages unique
    for (int i = 0; i < 512; i++) begin
      logic h;
      {cum_r_i, cum_w_i, part_r_i, part_w_i, ir_fault_i} = 5'(i >> 4);
      {dir_fetch_err_i, entry_rw_clear_i, entry_invalid_i, entry_rsvd_i} = 4'(i);
      walk_did_i = 16'h0003;
      walk_page_i = {11'($random(seed)), 9'(i)};
      walk_xlate_i = 20'($random(seed));
      {tlb_fill_i, nl_fill_i, iec_fill_i} = 3'h7;
      h = (4'(i) == 4'h0) && (cum_r_i || cum_w_i);
      if (h) last_pg = walk_page_i;
      step;
      chk("tlb_taken", tlb_fill_taken_o, h);
      chk("nl_taken", nl_fill_taken_o, 4'(i) == 4'h0 && (part_r_i || part_w_i));
      chk("iec_taken", iec_fill_taken_o, !ir_fault_i);
      {tlb_fill_i, nl_fill_i, iec_fill_i, tlb_lookup_i} = 4'h1;
      {tlb_lookup_did_i, tlb_lookup_page_i} = {walk_did_i, walk_page_i};
      step;
      tlb_lookup_i = 1'b0;
      chk("tlb_hit", tlb_hit_o, h);
      chk("tlb_xlate", tlb_xlate_o, h ? walk_xlate_i : 20'h0);
      chk("tlb_perm", {tlb_r_o, tlb_w_o}, h ? {cum_r_i, cum_w_i} : 2'h0);
    end
    // Software flush after context changes must empty the buffer
    tlb_flush_i = 1'b1;
    step;
    {tlb_flush_i, tlb_lookup_i, tlb_lookup_page_i} = {2'h1, last_pg};
    step;
    tlb_lookup_i = 1'b0;
    chk("tlb_flushed", tlb_hit_o, 1'b0);
    $display("test walk done");
    finish_test;
  end

  initial begin
    repeat (10000) @(posedge clk_i);
    num_errors++;
    $display("[ERR] watchdog expected end seen hang");
    finish_test;
  end
endmodule
